// ===== shared/lcd_pkg.sv
// Operation
// - setting the drive enable bit starts the waveform generator and clearing it stops it.
// - with drive enable clear every plane pin is released and all waveform clocks stand still.
// - with drive enable set, a frontplane pin carries a waveform only if its own enable is set.
// - with drive enable set, backplane pins are driven according to the backplane count field.
// - the waveform type bit picks normal waveforms at 0 and low-power waveforms at 1.
// - the prescale field divides the reference clock by 16 times two to its value for the base clock.
// - backplane count 01 is two, 10 is three, 11 is four backplanes, 00 is reserved, 11 at reset.
// - the shared plane pin is the top frontplane for two or three backplanes, else the fourth one.
// - both control registers read at any time and the drive enable bit writes at any time.
// - with the frame interrupt enable set each frame start, or sub-frame in low power, requests; IRQ also needs the irq_mask bit set, which resets clear.
// - the wait halt bit stops driver and charge pump in wait mode when set and not when clear.
// - the deep stop halt bit stops driver and charge pump in deep stop when set, not when clear.
// - blinking runs on in wait and deep stop, and segment memory is locked in those modes.
package lcd_pkg;
  // register map
  localparam logic [1:0] ADDR_CTRL_MAIN = 2'h0;
  localparam logic [1:0] ADDR_CTRL_POWER = 2'h1;
  localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
  // main control fields
  localparam int DRIVE_EN_BIT = 7;
  localparam int LP_WAVE_BIT = 6;
  localparam int PRESCALE_MSB = 5;
  localparam int PRESCALE_LSB = 3;
  localparam int BP_COUNT_MSB = 1;
  localparam int BP_COUNT_LSB = 0;
  // power control fields
  localparam int FRAME_IRQ_EN_BIT = 7;
  localparam int HALT_WAIT_BIT = 1;
  localparam int HALT_STOP_BIT = 0;
  // status and mask field
  localparam int FRAME_FLAG_BIT = 0;
  // reset values and writable bits
  localparam logic [7:0] CTRL_MAIN_RESET = 8'h03;
  localparam logic [7:0] CTRL_POWER_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_MAIN_WMASK = 8'hfb;
  localparam logic [7:0] CTRL_POWER_WMASK = 8'h83;
  localparam logic [7:0] IRQ_WMASK = 8'h01;
  // backplane count encodings
  localparam logic [1:0] BP_RESERVED = 2'h0;
  localparam logic [1:0] BP_TWO = 2'h1;
  localparam logic [1:0] BP_THREE = 2'h2;
  localparam logic [1:0] BP_FOUR = 2'h3;
  // prescaler base divide in reference ticks
  localparam int PRESCALE_BASE = 16;
  localparam int PRESCALE_WIDTH = 12;
  // pin counts
  localparam int FRONTPLANE_COUNT = 40;
  localparam int BACKPLANE_COUNT = 3;
  // driver state, one-hot
  typedef enum logic [2:0] {
    DRV_OFF = 3'b001,
    DRV_RUN = 3'b010,
    DRV_HALT = 3'b100
  } drive_state_e;
endpackage : lcd_pkg

// ===== rtl/level_sync.sv
module level_sync import lcd_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : level_sync

// ===== rtl/base_clock_prescaler.sv
module base_clock_prescaler import lcd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic ref_tick,
  input wire logic [2:0] prescale,
  // base clock enable
  output logic base_tick
);
  localparam logic [PRESCALE_WIDTH-1:0] BASE = PRESCALE_WIDTH'(PRESCALE_BASE);
  logic [PRESCALE_WIDTH-1:0] count;
  wire [PRESCALE_WIDTH-1:0] limit = (BASE << prescale) - PRESCALE_WIDTH'(1);
  wire wrap = ref_tick && (count >= limit);

  // divide by 16 * 2^n; the counter is held at zero while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      base_tick <= 1'b0;
    end else begin
      base_tick <= run && wrap;
      if (!run || wrap) begin
        count <= '0;
      end else if (ref_tick) begin
        count <= count + PRESCALE_WIDTH'(1);
      end
    end
  end
endmodule : base_clock_prescaler

// ===== rtl/lcd_waveform_control.sv
// Design decisions made here: the register addresses and strobed register access.
module lcd_waveform_control import lcd_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register port
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // reference clock pin, nominal 32.768 kHz
  input wire logic PANEL_REFERENCE_CLOCK,
  // processor power modes
  input wire logic WAIT_MODE,
  input wire logic DEEP_STOP_MODE,
  // per-pin frontplane enables, top bit is the shared plane pin
  input wire logic [FRONTPLANE_COUNT:0] FRONTPLANE_ENABLE,
  // plane pin drive
  output logic [FRONTPLANE_COUNT-1:0] FRONTPLANE_PINS_OE,
  output logic [BACKPLANE_COUNT-1:0] BACKPLANE_PINS_OE,
  output logic SHARED_PLANE_PIN_OE,
  output logic SHARED_PLANE_IS_BACKPLANE,
  // waveform timing
  output logic [1:0] WAVE_PHASE,
  output logic WAVE_POLARITY,
  output logic WAVE_LOW_POWER,
  // analog and memory control
  output logic CHARGE_PUMP_RUN,
  output logic BLINK_RUN,
  output logic SEGMENT_WRITE_LOCK,
  // interrupt
  output logic IRQ
);
  logic [7:0] display_control_main;
  logic [7:0] display_control_power;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  drive_state_e state;
  drive_state_e next_state;
  logic ref_sync;
  logic ref_prev;
  logic base_tick;
  logic [1:0] phase;
  logic polarity;

  // decode
  wire wr_main = WR && (ADDR == ADDR_CTRL_MAIN);
  wire wr_power = WR && (ADDR == ADDR_CTRL_POWER);
  wire wr_status = WR && (ADDR == ADDR_IRQ_STATUS);
  wire wr_mask = WR && (ADDR == ADDR_IRQ_MASK);

  // fields
  wire display_drive_enable = display_control_main[DRIVE_EN_BIT];
  wire low_power_waveform_select = display_control_main[LP_WAVE_BIT];
  wire [2:0] base_clock_prescale = display_control_main[PRESCALE_MSB:PRESCALE_LSB];
  wire [1:0] bp_count = display_control_main[BP_COUNT_MSB:BP_COUNT_LSB];
  wire frame_irq_enable = display_control_power[FRAME_IRQ_EN_BIT];
  wire halt_in_wait = display_control_power[HALT_WAIT_BIT];
  wire halt_in_deep_stop = display_control_power[HALT_STOP_BIT];

  // halt conditions
  wire halt_wait = WAIT_MODE && halt_in_wait;
  wire halt_stop = DEEP_STOP_MODE && halt_in_deep_stop;
  wire halted = halt_wait || halt_stop;

  // reserved count 00 is treated as four so the shared pin never floats mid-frame
  wire four_bp = (bp_count == BP_FOUR) || (bp_count == BP_RESERVED);
  wire [1:0] last_phase = (bp_count == BP_TWO) ? 2'h1 :
                          (bp_count == BP_THREE) ? 2'h2 : 2'h3;
  wire [BACKPLANE_COUNT-1:0] bp_mask = (bp_count == BP_TWO) ? 3'h3 : 3'h7;

  // state
  wire running = (state == DRV_RUN);
  wire ref_tick = ref_sync && !ref_prev;
  wire phase_wrap = base_tick && (phase == last_phase);
  wire next_polarity = phase_wrap ? !polarity : polarity;
  // low power flags every sub-frame, normal only when a full frame restarts
  wire frame_start = phase_wrap && (low_power_waveform_select || polarity);
  wire frame_set = frame_start && frame_irq_enable;

  // read mux, reserved bits read zero
  wire [7:0] read_value = (ADDR == ADDR_CTRL_MAIN) ? display_control_main :
                          (ADDR == ADDR_CTRL_POWER) ? display_control_power :
                          (ADDR == ADDR_IRQ_STATUS) ? irq_status : irq_mask;

  // pin enables
  wire [FRONTPLANE_COUNT-1:0] next_fp_oe =
    running ? FRONTPLANE_ENABLE[FRONTPLANE_COUNT-1:0] : '0;
  wire [BACKPLANE_COUNT-1:0] next_bp_oe = running ? bp_mask : '0;
  wire next_shared_oe = running && (four_bp || FRONTPLANE_ENABLE[FRONTPLANE_COUNT]);
  wire next_irq = |(irq_status & irq_mask) && frame_irq_enable;

  level_sync #(
    .WIDTH(1)
  ) u_ref_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .async_in(PANEL_REFERENCE_CLOCK),
    .sync_out(ref_sync)
  );

  base_clock_prescaler u_prescaler (
    .clk(CLK),
    .rst_b(RST_B),
    .run(running),
    .ref_tick(ref_tick),
    .prescale(base_clock_prescale),
    .base_tick(base_tick)
  );

  // driver state
  always_comb begin
    case (state)
      DRV_OFF: next_state = display_drive_enable ? (halted ? DRV_HALT : DRV_RUN) : DRV_OFF;
      DRV_RUN: next_state = !display_drive_enable ? DRV_OFF : (halted ? DRV_HALT : DRV_RUN);
      DRV_HALT: next_state = !display_drive_enable ? DRV_OFF : (halted ? DRV_HALT : DRV_RUN);
      default: next_state = DRV_OFF;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= DRV_OFF;
    end else begin
      state <= next_state;
    end
  end

  // control registers, all fields written at any time
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      display_control_main <= CTRL_MAIN_RESET;
      display_control_power <= CTRL_POWER_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      if (wr_main) begin
        display_control_main <= WDATA & CTRL_MAIN_WMASK;
      end
      if (wr_power) begin
        display_control_power <= WDATA & CTRL_POWER_WMASK;
      end
      if (wr_mask) begin
        irq_mask <= WDATA & IRQ_WMASK;
      end
    end
  end

  // pending flag: a new frame start wins over a write-one clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_status <= '0;
    end else begin
      irq_status[FRAME_FLAG_BIT] <= frame_set ||
        (irq_status[FRAME_FLAG_BIT] && !(wr_status && WDATA[FRAME_FLAG_BIT]));
    end
  end

  // reference edge and waveform phase; phase and polarity held at zero unless running
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_prev <= 1'b0;
      phase <= 2'h0;
      polarity <= 1'b0;
    end else begin
      ref_prev <= ref_sync;
      if (!running) begin
        phase <= 2'h0;
        polarity <= 1'b0;
      end else if (base_tick) begin
        phase <= phase_wrap ? 2'h0 : phase + 2'h1;
        polarity <= next_polarity;
      end
    end
  end

  // registered outputs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
      FRONTPLANE_PINS_OE <= '0;
      BACKPLANE_PINS_OE <= '0;
      SHARED_PLANE_PIN_OE <= 1'b0;
      SHARED_PLANE_IS_BACKPLANE <= 1'b1;
      WAVE_PHASE <= 2'h0;
      WAVE_POLARITY <= 1'b0;
      WAVE_LOW_POWER <= 1'b0;
      CHARGE_PUMP_RUN <= 1'b0;
      BLINK_RUN <= 1'b0;
      SEGMENT_WRITE_LOCK <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? read_value : 8'h00;
      FRONTPLANE_PINS_OE <= next_fp_oe;
      BACKPLANE_PINS_OE <= next_bp_oe;
      SHARED_PLANE_PIN_OE <= next_shared_oe;
      SHARED_PLANE_IS_BACKPLANE <= four_bp;
      WAVE_PHASE <= phase;
      WAVE_POLARITY <= polarity;
      WAVE_LOW_POWER <= low_power_waveform_select;
      CHARGE_PUMP_RUN <= display_drive_enable && !halted;
      BLINK_RUN <= display_drive_enable;
      SEGMENT_WRITE_LOCK <= WAIT_MODE || DEEP_STOP_MODE;
      IRQ <= next_irq;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_tick_at_last;
    base_tick && running && (phase == last_phase);
  endsequence

  a_drive_off_quiet: assert property (
    !display_drive_enable ##1 !display_drive_enable |=>
      (FRONTPLANE_PINS_OE == '0) && (BACKPLANE_PINS_OE == '0) && !SHARED_PLANE_PIN_OE)
    else $error("plane pins driven while drive is off");

  a_enable_starts: assert property (
    $rose(display_drive_enable) && !halted ##1 !halted |-> running)
    else $error("generator not started by drive enable");

  a_frontplane_follows: assert property (
    running |=> FRONTPLANE_PINS_OE == $past(FRONTPLANE_ENABLE[FRONTPLANE_COUNT-1:0]))
    else $error("frontplane enable not followed");

  a_backplane_count: assert property (
    running && (bp_count == BP_TWO) |=> BACKPLANE_PINS_OE == 3'h3)
    else $error("wrong backplanes for two-plane setting");

  a_shared_as_bp: assert property (
    running && (bp_count == BP_FOUR) |=> SHARED_PLANE_PIN_OE && SHARED_PLANE_IS_BACKPLANE)
    else $error("shared pin not a backplane with four planes");

  a_phase_wraps: assert property (
    s_tick_at_last ##1 running |-> phase == 2'h0)
    else $error("phase did not wrap at last backplane");

  a_frame_flag_set: assert property (
    frame_set |=> irq_status[FRAME_FLAG_BIT])
    else $error("frame start lost");

  a_no_flag_disabled: assert property (
    !frame_irq_enable && !irq_status[FRAME_FLAG_BIT] |=> !irq_status[FRAME_FLAG_BIT])
    else $error("flag set while interrupt disabled");

  a_irq_gated: assert property (
    !frame_irq_enable |=> !IRQ)
    else $error("request not gated by enable");

  a_wait_halts: assert property (
    WAIT_MODE && halt_in_wait |=> !CHARGE_PUMP_RUN && !running)
    else $error("driver runs in wait with halt set");

  a_stop_halts: assert property (
    DEEP_STOP_MODE && halt_in_deep_stop |=> !CHARGE_PUMP_RUN)
    else $error("pump runs in deep stop with halt set");

  a_read_main: assert property (
    RD && (ADDR == ADDR_CTRL_MAIN) |=> RDATA == $past(display_control_main))
    else $error("main control read mismatch");

  a_memory_lock: assert property (
    WAIT_MODE || DEEP_STOP_MODE |=> SEGMENT_WRITE_LOCK)
    else $error("segment memory not locked");

  sequence s_flag_pending;
    irq_status[FRAME_FLAG_BIT] && irq_mask[FRAME_FLAG_BIT];
  endsequence

  a_off_pump_idle: assert property (
    !display_drive_enable |=> !CHARGE_PUMP_RUN && !BLINK_RUN)
    else $error("pump or blink runs while drive is off");

  a_off_phase_reset: assert property (
    !running |=> (phase == 2'h0) && !polarity)
    else $error("waveform phase moves while stopped");

  a_off_no_tick: assert property (
    !running |=> !base_tick)
    else $error("base clock runs while stopped");

  a_wave_type_copy: assert property (
    1'b1 |=> WAVE_LOW_POWER == $past(low_power_waveform_select))
    else $error("waveform type output mismatch");

  a_three_planes: assert property (
    running && (bp_count == BP_THREE) |=> (BACKPLANE_PINS_OE == 3'h7) && !SHARED_PLANE_IS_BACKPLANE)
    else $error("wrong backplanes for three-plane setting");

  a_shared_as_fp: assert property (
    running && ((bp_count == BP_TWO) || (bp_count == BP_THREE)) |=>
      SHARED_PLANE_PIN_OE == $past(FRONTPLANE_ENABLE[FRONTPLANE_COUNT]))
    else $error("shared pin not a frontplane");

  a_phase_steps: assert property (
    base_tick && running && (phase != last_phase) |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance on base tick");

  a_polarity_flips: assert property (
    s_tick_at_last |=> polarity != $past(polarity))
    else $error("polarity did not flip at wrap");

  a_tick_spacing: assert property (
    base_tick |=> !base_tick)
    else $error("base clock ticks back to back");

  a_lp_subframe: assert property (
    s_tick_at_last ##0 (low_power_waveform_select && frame_irq_enable) |=>
      irq_status[FRAME_FLAG_BIT])
    else $error("sub-frame start not flagged");

  a_normal_frame: assert property (
    s_tick_at_last ##0 (!low_power_waveform_select && polarity && frame_irq_enable) |=>
      irq_status[FRAME_FLAG_BIT])
    else $error("frame start not flagged");

  a_flag_cleared: assert property (
    wr_status && WDATA[FRAME_FLAG_BIT] && !frame_set |=> !irq_status[FRAME_FLAG_BIT])
    else $error("write one did not clear flag");

  a_flag_sticky: assert property (
    irq_status[FRAME_FLAG_BIT] && !wr_status |=> irq_status[FRAME_FLAG_BIT])
    else $error("pending flag lost");

  a_irq_raised: assert property (
    s_flag_pending ##0 frame_irq_enable |=> IRQ)
    else $error("request not raised for pending flag");

  a_stop_halts_drv: assert property (
    DEEP_STOP_MODE && halt_in_deep_stop |=> !running)
    else $error("driver runs in deep stop with halt set");

  a_wait_keeps: assert property (
    WAIT_MODE && !halt_in_wait && !halt_stop && display_drive_enable |=> CHARGE_PUMP_RUN)
    else $error("pump stopped in wait with halt clear");

  a_stop_keeps: assert property (
    DEEP_STOP_MODE && !halt_in_deep_stop && !halt_wait && display_drive_enable |=>
      CHARGE_PUMP_RUN)
    else $error("pump stopped in deep stop with halt clear");

  a_blink_follows: assert property (
    display_drive_enable |=> BLINK_RUN)
    else $error("blink stopped while drive is on");

  a_read_power: assert property (
    RD && (ADDR == ADDR_CTRL_POWER) |=> RDATA == $past(display_control_power))
    else $error("power control read mismatch");

  a_read_idle: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");

  a_main_write: assert property (
    wr_main |=> display_control_main == ($past(WDATA) & CTRL_MAIN_WMASK))
    else $error("main control write lost");
endmodule : lcd_waveform_control

// ===== testbench/lcd_panel_model.sv
module lcd_panel_model import lcd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // plane drive seen at the glass
  input wire logic [BACKPLANE_COUNT-1:0] backplane_oe,
  input wire logic shared_oe,
  input wire logic shared_is_bp,
  input wire logic polarity,
  // frame halves seen while a backplane is driven
  output int halves_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_pol;
  logic driven;
  // the glass only sees a frame while some backplane is really driven
  assign driven = (|backplane_oe) || (shared_oe && shared_is_bp);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_pol <= 1'b0;
      halves_seen <= 0;
    end else begin
      last_pol <= polarity;
      if (driven && polarity !== last_pol) begin
        halves_seen <= halves_seen + 1;
      end
    end
  end
endmodule : lcd_panel_model

// ===== testbench/lcd_waveform_control_tb.sv
module lcd_waveform_control_tb import lcd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b, wr, rd, ref_clk, wait_mode, stop_mode;
  logic [1:0] addr, phase, mx;
  logic [7:0] wdata, rdata;
  logic [40:0] fp_en;
  logic [39:0] fp_oe;
  logic [2:0] bp_oe;
  logic sh_oe, sh_bp, pol, lp, pump, blink, lock, irq;
  int n_errors = 0;
  int total_checks = 0;
  int halves, n, h0;
  always #2.5 clk = ~clk;
  // reference runs on in every mode, as the external source would
  initial begin
    ref_clk = 1'b0;
    #1;
    forever #20 ref_clk = ~ref_clk;
  end
  lcd_waveform_control DUT (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PANEL_REFERENCE_CLOCK(ref_clk), .WAIT_MODE(wait_mode),
    .DEEP_STOP_MODE(stop_mode), .FRONTPLANE_ENABLE(fp_en), .FRONTPLANE_PINS_OE(fp_oe),
    .BACKPLANE_PINS_OE(bp_oe), .SHARED_PLANE_PIN_OE(sh_oe), .SHARED_PLANE_IS_BACKPLANE(sh_bp),
    .WAVE_PHASE(phase), .WAVE_POLARITY(pol), .WAVE_LOW_POWER(lp), .CHARGE_PUMP_RUN(pump),
    .BLINK_RUN(blink), .SEGMENT_WRITE_LOCK(lock), .IRQ(irq));
  lcd_panel_model panel (.clk(clk), .rst_b(rst_b), .backplane_oe(bp_oe), .shared_oe(sh_oe),
    .shared_is_bp(sh_bp), .polarity(pol), .halves_seen(halves));
  task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_gap(input int got, input int exp);
    total_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_gap
  task automatic step(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask : step
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check_val(rdata, exp);
  endtask : rd_chk
  task automatic wait_irq(input logic lvl);
    int k;
    k = 0;
    while (irq !== lvl && k < 3000) begin
      step(1);
      k++;
    end
    if (k == 3000) check_val(irq, lvl);
  endtask : wait_irq
  task automatic tick_gap(output int k);
    logic [1:0] p0;
    p0 = phase;
    k = 0;
    while (phase === p0 && k < 2000) begin
      step(1);
      k++;
    end
  endtask : tick_gap
  // clears the pending flag between two requests; the gap is in clock cycles
  task automatic irq_gap(output int k);
    realtime t0;
    wait_irq(1'b1);
    t0 = $realtime;
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    wait_irq(1'b1);
    k = int'(($realtime - t0) / 5.0);
  endtask : irq_gap
  task automatic end_test(input string s);
    $display("test %s done, errors %0d", s, n_errors);
  endtask : end_test
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    {wr, rd, wait_mode, stop_mode, addr, wdata} = '0;
    fp_en = 41'h0a5c31e967b;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    step(2);
    check_val(sh_bp, 1'b1);
    check_val({bp_oe, sh_oe, blink}, '0);
    rd_chk(ADDR_CTRL_MAIN, 8'h03);
    rd_chk(ADDR_CTRL_POWER, 8'h00);
    wr_reg(ADDR_CTRL_MAIN, 8'h04);
    rd_chk(ADDR_CTRL_MAIN, 8'h00);
    wr_reg(ADDR_IRQ_MASK, 8'hff);
    rd_chk(ADDR_IRQ_MASK, 8'h01);
    end_test("reset");
    // prescale and count only change while the driver is off
    for (int d = 1; d <= 3; d++) begin
      @(posedge clk);
      fp_en[40] <= (d == 2);
      wr_reg(ADDR_CTRL_MAIN, 8'(((d - 1) << 3) | d));
      step(1);
      check_val(sh_bp, d == 3);
      wr_reg(ADDR_CTRL_MAIN, 8'(8'h80 | ((d - 1) << 3) | d));
      step(3);
      check_val(bp_oe, (d == 1) ? 3'b011 : 3'b111);
      check_val(fp_oe, fp_en[39:0]);
      check_val({sh_oe, pump, lp}, {d != 1, 2'b10});
      tick_gap(n);
      tick_gap(n);
      check_gap(n, 128 << (d - 1));
      h0 = halves;
      mx = '0;
      repeat (2 * (d + 1)) begin
        tick_gap(n);
        if (phase > mx) mx = phase;
      end
      check_val(mx, d);
      check_val(halves > h0, 1'b1);
      wr_reg(ADDR_CTRL_MAIN, 8'(((d - 1) << 3) | d));
      step(3);
      check_val({fp_oe, bp_oe, sh_oe, blink}, '0);
      h0 = halves;
      step(600);
      check_val({halves == h0, phase}, 3'b100);
    end
    end_test("duty");
    wr_reg(ADDR_CTRL_MAIN, 8'h03);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    wr_reg(ADDR_CTRL_POWER, 8'h80);
    wr_reg(ADDR_CTRL_MAIN, 8'h83);
    irq_gap(n);
    irq_gap(n);
    check_gap(n, 1024);
    wr_reg(ADDR_IRQ_MASK, 8'h00);
    step(2);
    check_val(irq, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 8'h01);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    step(2);
    check_val(irq, 1'b1);
    wr_reg(ADDR_CTRL_MAIN, 8'hc3);
    step(2);
    check_val(lp, 1'b1);
    irq_gap(n);
    irq_gap(n);
    check_gap(n, 512);
    wr_reg(ADDR_CTRL_POWER, 8'h00);
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    step(1100);
    check_val(irq, 1'b0);
    rd_chk(ADDR_IRQ_STATUS, 8'h00);
    end_test("interrupt");
    for (int m = 0; m < 2; m++) begin
      for (int h = 0; h < 2; h++) begin
        wr_reg(ADDR_CTRL_POWER, 8'(h << (m == 0 ? HALT_WAIT_BIT : HALT_STOP_BIT)));
        @(posedge clk);
        wait_mode <= (m == 0);
        stop_mode <= (m == 1);
        step(4);
        check_val({pump, bp_oe}, h ? 4'h0 : 4'hf);
        check_val({blink, lock}, 2'b11);
        @(posedge clk);
        wait_mode <= 1'b0;
        stop_mode <= 1'b0;
        step(4);
        check_val({pump, lock}, 2'b10);
      end
    end
    wr_reg(ADDR_CTRL_POWER, 8'hff);
    rd_chk(ADDR_CTRL_POWER, 8'h83);
    end_test("halt");
    close_out();
  end
endmodule : lcd_waveform_control_tb
